/* File: hdl/pfs_ctrl.sv */
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ps

// What this block does
// - Latch serial pin levels once at start-up
// - Eight-row table gives synth one dividers
// - Third select switches synth one, A, B
// - A and B: 7-bit divider from two banks
// - One bank select shared by A and B
// - Divider changes applied glitch-free, all at once
// - Each synth holds 8-bit Q, 11-bit P
// - Synth one feeds out E divider /2,/3,/4
// - Synth one set by software or selects
// - Synths two, three set only by software
// - Shutdown low: outputs off, chip off (default)
// - Option: shutdown low only disables outputs
// - Suspend pin is index bit 2 or suspend
// - Full shutdown stops synths, oscillator; relock after
// - Suspend low disables selected synths and outputs
module pfs_ctrl
    import pfs_pkg::*;
#(
    parameter int STRAP_CYC = STRAP_WAIT
) (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Pins
    input  wire logic              serial_data_pin,
    input  wire logic              serial_clock_pin,
    input  wire logic              select_bit_two,
    input  wire logic              shutdown_oe_n,
    // Synthesizer settings
    output pfs_synth_t             synth_one_cfg,
    output pfs_synth_t             synth_two_cfg,
    output pfs_synth_t             synth_three_cfg,
    output logic      [2:0]        synth_run,
    output logic                   osc_run,
    output logic                   relock,
    // Output dividers and enables
    output pfs_divs_t              divs,
    output logic                   divs_update,
    output logic      [4:0]        out_en
);

    initial begin
        if (STRAP_CYC < 4 || STRAP_CYC > 255) begin
            $error("STRAP_CYC out of range");
        end
    end

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    // Three stages; a change counts only once stages two and three agree
    logic [3:0] pin_raw;
    logic [3:0] s1_r;
    logic [3:0] s2_r;
    logic [3:0] s3_r;
    logic [3:0] pin_r;

    assign pin_raw = {shutdown_oe_n, select_bit_two, serial_clock_pin, serial_data_pin};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    s1_r[gi]  <= 1'b0;
                    s2_r[gi]  <= 1'b0;
                    s3_r[gi]  <= 1'b0;
                    pin_r[gi] <= 1'b0;
                end else begin
                    s1_r[gi] <= pin_raw[gi];
                    s2_r[gi] <= s1_r[gi];
                    s3_r[gi] <= s2_r[gi];
                    if (s2_r[gi] == s3_r[gi]) begin
                        pin_r[gi] <= s3_r[gi];
                    end
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Start-up strap capture
    // ----------------------------------------
    logic [7:0] strap_cnt_r;
    logic       strap_ok_r;
    logic [1:0] strap_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_cnt_r <= 8'h00;
            strap_ok_r  <= 1'b0;
            strap_r     <= 2'h0;
        end else if (!strap_ok_r) begin
            strap_cnt_r <= strap_cnt_r + 8'h01;
            // Pin stages restart from reset, so pin_r is valid four edges after release
            if (strap_cnt_r == 8'(STRAP_CYC)) begin
                strap_ok_r <= 1'b1;
                strap_r    <= pin_r[1:0];
            end
        end
        // Once captured, later serial traffic is ignored
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [31:0]      ctrl_r;
    pfs_synth_t       syn2_r;
    pfs_synth_t       syn3_r;
    logic [DIV_W-1:0] diva_r [2];
    logic [DIV_W-1:0] divb_r [2];
    logic [DIV_W-1:0] divc_r;
    logic [DIV_W-1:0] divd_r;
    logic [1:0]       esel_r;
    pfs_row_t         tab_r [ROWS];

    logic       wr_en;
    logic       acc;
    logic       tab_hit;
    logic [2:0] tab_idx;

    assign acc     = psel & penable & ~pready;
    assign wr_en   = acc & pwrite;
    assign tab_hit = (paddr >= OFS_TAB0) && (paddr <= OFS_TABEND) && (paddr[1:0] == 2'h0);
    assign tab_idx = paddr[4:2];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= CTRL_RST;
        end else if (wr_en && paddr == OFS_CTRL) begin
            ctrl_r <= {22'h0, pwdata[9:0]};
        end
    end

    // Synths two and three are software-only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            syn2_r <= '0;
            syn3_r <= '0;
        end else if (wr_en) begin
            if (paddr == OFS_SYN2) begin
                syn2_r <= pwdata[Q_W+P_W-1:0];
            end
            if (paddr == OFS_SYN3) begin
                syn3_r <= pwdata[Q_W+P_W-1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            diva_r <= '{default: '0};
            divb_r <= '{default: '0};
            divc_r <= '0;
            divd_r <= '0;
            esel_r <= ESEL_DIV2;
        end else if (wr_en) begin
            case (paddr)
                OFS_DIVA: begin
                    diva_r[0] <= pwdata[DIV_W-1:0];
                    diva_r[1] <= pwdata[DIV_BANK1 +: DIV_W];
                end
                OFS_DIVB: begin
                    divb_r[0] <= pwdata[DIV_W-1:0];
                    divb_r[1] <= pwdata[DIV_BANK1 +: DIV_W];
                end
                OFS_DIVCDE: begin
                    divc_r <= pwdata[DIV_W-1:0];
                    divd_r <= pwdata[DIV_D +: DIV_W];
                    // Only /2, /3, /4 exist; an unused code is refused
                    if (pwdata[DIV_ESEL +: 2] != 2'h3) begin
                        esel_r <= pwdata[DIV_ESEL +: 2];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Table rows, each its own Q/P pair and bank choice
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tab_r <= '{default: '0};
        end else if (wr_en && tab_hit) begin
            tab_r[tab_idx] <= '{bank: pwdata[TAB_BANK], p: pwdata[SYN_P +: P_W], q: pwdata[Q_W-1:0]};
        end
    end

    // ----------------------------------------
    // Frequency selection
    // ----------------------------------------
    logic             susp_mode;
    logic             bit2;
    logic [IDX_W-1:0] row_idx;
    pfs_row_t         row;
    pfs_divs_t        divs_nxt;

    assign susp_mode = ctrl_r[CTRL_SUSPEN];
    assign bit2      = susp_mode ? 1'b0 : pin_r[2];
    assign row_idx   = {bit2, strap_r};
    assign row       = tab_r[row_idx];

    // One bank bit drives A and B together
    always_comb begin
        divs_nxt.a     = diva_r[row.bank];
        divs_nxt.b     = divb_r[row.bank];
        divs_nxt.c     = divc_r;
        divs_nxt.d     = divd_r;
        divs_nxt.e_sel = esel_r;
    end

    // All divider fields move on one edge, with a marker, so the output
    // counters can reload at their terminal count and never cut a pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            divs          <= '0;
            divs_update   <= 1'b0;
            synth_one_cfg <= '0;
        end else begin
            divs          <= divs_nxt;
            divs_update   <= (divs_nxt != divs);
            synth_one_cfg <= '{p: row.p, q: row.q};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            synth_two_cfg   <= '0;
            synth_three_cfg <= '0;
        end else begin
            synth_two_cfg   <= syn2_r;
            synth_three_cfg <= syn3_r;
        end
    end

    // ----------------------------------------
    // Power control
    // ----------------------------------------
    logic       sd_low;
    logic       full_sd;
    logic       susp;
    logic [2:0] run_nxt;
    logic       run_any_r;

    assign sd_low  = ~pin_r[3];
    assign full_sd = sd_low & ctrl_r[CTRL_FULLSD];
    assign susp    = susp_mode & ~pin_r[2];
    // Software keeps suspended outputs a superset of their synths
    assign run_nxt = full_sd ? 3'h0 : (susp ? ~ctrl_r[CTRL_SMSYN +: 3] : 3'h7);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_en    <= 5'h00;
            synth_run <= 3'h0;
            osc_run   <= 1'b1;
            relock    <= 1'b0;
            run_any_r <= 1'b0;
        end else begin
            out_en    <= (sd_low || !strap_ok_r) ? 5'h00 :
                         (susp ? ~ctrl_r[CTRL_SMOUT +: 5] : 5'h1f);
            synth_run <= run_nxt;
            osc_run   <= ~full_sd;
            run_any_r <= ~full_sd;
            relock    <= ~full_sd & ~run_any_r;
        end
    end

    // ----------------------------------------
    // APB read and answer
    // ----------------------------------------
    logic [31:0] rd_nxt;
    logic        err_nxt;

    always_comb begin
        rd_nxt  = 32'h0000_0000;
        err_nxt = 1'b0;
        if (tab_hit) begin
            rd_nxt = {11'h0, tab_r[tab_idx].bank, 1'b0, tab_r[tab_idx].p, tab_r[tab_idx].q};
        end else begin
            case (paddr)
                OFS_CTRL:   rd_nxt = ctrl_r;
                OFS_STAT:   rd_nxt = {25'h0, row.bank, susp, sd_low, strap_ok_r, row_idx};
                OFS_SYN2:   rd_nxt = {13'h0, syn2_r};
                OFS_SYN3:   rd_nxt = {13'h0, syn3_r};
                OFS_DIVA:   rd_nxt = {17'h0, diva_r[1], 1'b0, diva_r[0]};
                OFS_DIVB:   rd_nxt = {17'h0, divb_r[1], 1'b0, divb_r[0]};
                OFS_DIVCDE: rd_nxt = {14'h0, esel_r, 1'b0, divd_r, 1'b0, divc_r};
                default:    err_nxt = 1'b1;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= acc;
            pslverr <= acc & err_nxt;
            prdata  <= (acc && !pwrite && !err_nxt) ? rd_nxt : 32'h0000_0000;
        end
    end

endmodule : pfs_ctrl

/* File: hdl/pfs_pkg.sv */
package pfs_pkg;

    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int Q_W   = 8;
    localparam int P_W   = 11;
    localparam int DIV_W = 7;
    localparam int ROWS  = 8;
    localparam int IDX_W = 3;

    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STAT   = 8'h04;
    localparam logic [7:0] OFS_SYN2   = 8'h08;
    localparam logic [7:0] OFS_SYN3   = 8'h0c;
    localparam logic [7:0] OFS_DIVA   = 8'h10;
    localparam logic [7:0] OFS_DIVB   = 8'h14;
    localparam logic [7:0] OFS_DIVCDE = 8'h18;
    localparam logic [7:0] OFS_TAB0   = 8'h20;
    localparam logic [7:0] OFS_TABEND = 8'h3c;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int CTRL_FULLSD  = 0;
    localparam int CTRL_SUSPEN  = 1;
    localparam int CTRL_SMSYN   = 2;  // 3 bits: synth one..three
    localparam int CTRL_SMOUT   = 5;  // 5 bits: out a..e
    localparam int SYN_P        = 8;
    localparam int DIV_BANK1    = 8;
    localparam int DIV_D        = 8;
    localparam int DIV_ESEL     = 16;
    localparam int TAB_BANK     = 20;
    localparam int STAT_STRAPOK = 3;
    localparam int STAT_SD      = 4;
    localparam int STAT_SUSP    = 5;
    localparam int STAT_BANK    = 6;

    // ----------------------------------------
    // Reset values and timing
    // ----------------------------------------
    localparam logic [31:0] CTRL_RST     = 32'h0000_0001;
    localparam int          STRAP_WAIT   = 8;
    localparam logic [1:0]  ESEL_DIV2    = 2'h0;
    localparam logic [1:0]  ESEL_DIV3    = 2'h1;
    localparam logic [1:0]  ESEL_DIV4    = 2'h2;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef struct packed {
        logic [P_W-1:0] p;
        logic [Q_W-1:0] q;
    } pfs_synth_t;

    typedef struct packed {
        logic             bank;
        logic [P_W-1:0]   p;
        logic [Q_W-1:0]   q;
    } pfs_row_t;

    typedef struct packed {
        logic [DIV_W-1:0] a;
        logic [DIV_W-1:0] b;
        logic [DIV_W-1:0] c;
        logic [DIV_W-1:0] d;
        logic [1:0]       e_sel;
    } pfs_divs_t;

endpackage : pfs_pkg

/* File: dv/pfs_ctrl_props.sv */
`timescale 1ns/1ps
module pfs_ctrl_props
    import pfs_pkg::*;
(
    // Clock and APB
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    // Pins and controls
    input wire logic        shutdown_oe_n,
    input wire logic [4:0]  out_en,
    input wire logic [2:0]  synth_run,
    input wire logic        osc_run,
    input wire logic        relock,
    input wire pfs_divs_t   divs,
    input wire logic        divs_update
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----
    // Sequences
    // ----
    sequence taken_s;
        psel && penable && !pready;
    endsequence
    // Six samples cover the pin synchroniser and the output register
    sequence sd_low_s;
        !shutdown_oe_n [*6];
    endsequence
    a_one_wait: assert property (taken_s |=> pready)
        else $error("pready missing after access");
    a_ready_cause: assert property (pready |-> $past(psel && penable))
        else $error("pready without access");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr outside answer");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero when idle");
    a_sd_off: assert property (sd_low_s |-> out_en == 5'h0)
        else $error("outputs driven in shutdown");
    a_fsd_stops: assert property (!osc_run |-> synth_run == 3'h0 && out_en == 5'h0)
        else $error("synth running with oscillator off");
    a_relock_pulse: assert property (relock |=> !relock)
        else $error("relock longer than one cycle");
    a_relock_run: assert property (relock |-> osc_run)
        else $error("relock while oscillator off");
    a_upd_marker: assert property ($changed(divs) |-> divs_update)
        else $error("divider change without marker");
endmodule : pfs_ctrl_props

/* File: dv/pfs_pin_model.sv */
`timescale 1ns/1ps
module pfs_pin_model (
    // Bench controls
    input wire logic       pclk,
    input wire logic [1:0] strap,
    input wire logic       sel,
    input wire logic       sd,
    input wire logic       noise,
    // Board pins
    output logic           serial_data_pin,
    output logic           serial_clock_pin,
    output logic           select_bit_two,
    output logic           shutdown_oe_n
);
    logic tgl = 1'b0;
    // Serial traffic after start-up toggles both shared pins every cycle
    always @(posedge pclk) tgl <= ~tgl;
    assign serial_data_pin  = noise ? tgl : strap[0];
    assign serial_clock_pin = noise ? ~tgl : strap[1];
    assign select_bit_two   = sel;
    assign shutdown_oe_n    = sd;
endmodule : pfs_pin_model

/* File: dv/pfs_ctrl_tb.sv */
`timescale 1ns/1ps
module pfs_ctrl_tb;
    import pfs_pkg::*;
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic [1:0]  strap   = 2'h0;
    logic        sel     = 1'b0;
    logic        sd      = 1'b1;
    logic        noise   = 1'b0;
    logic [31:0] prdata, rd_data;
    logic        pready, pslverr, rd_err, osc_run, relock, divs_update, seen, b;
    logic        serial_data_pin, serial_clock_pin, select_bit_two, shutdown_oe_n;
    pfs_synth_t  synth_one_cfg, synth_two_cfg, synth_three_cfg;
    pfs_divs_t   divs;
    logic [2:0]  synth_run;
    logic [4:0]  out_en;
    int          fails = 0;
    int          cmp_count = 0;
    int          ix;

    always #12.5 pclk = ~pclk;

    pfs_pin_model pins_u (.pclk(pclk), .strap(strap), .sel(sel), .sd(sd), .noise(noise),
        .serial_data_pin(serial_data_pin), .serial_clock_pin(serial_clock_pin),
        .select_bit_two(select_bit_two), .shutdown_oe_n(shutdown_oe_n));
    pfs_ctrl #(.STRAP_CYC(4)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .serial_data_pin(serial_data_pin),
        .serial_clock_pin(serial_clock_pin), .select_bit_two(select_bit_two),
        .shutdown_oe_n(shutdown_oe_n), .synth_one_cfg(synth_one_cfg), .synth_two_cfg(synth_two_cfg),
        .synth_three_cfg(synth_three_cfg), .synth_run(synth_run), .osc_run(osc_run),
        .relock(relock), .divs(divs), .divs_update(divs_update), .out_en(out_en));
    // ----
    // Tasks
    // ----
    task automatic end_of_test;
        if (fails == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_of_test

    task automatic chk(input string nm, input logic [63:0] sv, input logic [63:0] ev);
        cmp_count++;
        if (sv !== ev) begin
            fails++;
            $display("BAD %s exp %h seen %h", nm, ev, sv);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            fails++;
            end_of_test();
        end
        rd_data = prdata;
        rd_err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Pins pass a synchroniser; eight cycles covers it and the output register
    task automatic wt;
        repeat (8) @(posedge pclk);
    endtask : wt
    // ----
    // Sequence
    // ----
    initial begin
        for (int s = 0; s < 4; s++) begin
            presetn <= 1'b0;
            strap   <= s[1:0];
            repeat (4) @(posedge pclk);
            presetn <= 1'b1;
            apb(1'b0, OFS_CTRL, 32'h0);
            chk("ctrl_rst", rd_data, CTRL_RST);
            for (int r = 0; r < 8; r++)
                apb(1'b1, OFS_TAB0 + 8'(4 * r), {11'h0, r[0] ^ r[2], 1'b0, 11'h100 + 11'(r), 8'h10 + 8'(r)});
            apb(1'b1, OFS_DIVA, 32'h2a11);
            apb(1'b1, OFS_DIVB, 32'h3344);
            for (int k = 0; k < 2; k++) begin
                sel <= k[0];
                wt();
                ix = k * 4 + s;
                b  = ix[0] ^ ix[2];
                chk("cfg1", synth_one_cfg, {11'h100 + 11'(ix), 8'h10 + 8'(ix)});
                chk("div_a", divs.a, b ? 7'h2a : 7'h11);
                chk("div_b", divs.b, b ? 7'h33 : 7'h44);
                apb(1'b0, OFS_STAT, 32'h0);
                chk("index", rd_data[3:0], {1'b1, 3'(ix)});
                chk("bank_flag", rd_data[6], b);
            end
        end
        noise <= 1'b1;
        wt();
        apb(1'b0, OFS_STAT, 32'h0);
        chk("strap_hold", rd_data[3:0], 4'hf);
        chk("cfg_hold", synth_one_cfg, {11'h107, 8'h17});
        noise <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, OFS_DIVCDE, {14'h0, 2'(k), 1'b0, 7'h05, 1'b0, 7'h06});
            wt();
            chk("e_sel", divs.e_sel, (k == 3) ? ESEL_DIV4 : 2'(k));
            chk("div_cd", {divs.d, divs.c}, {7'h05, 7'h06});
        end
        apb(1'b1, OFS_SYN2, 32'h5a53c);
        apb(1'b1, OFS_SYN3, 32'h12345);
        sel <= 1'b0;
        wt();
        chk("cfg2", synth_two_cfg, 19'h5a53c);
        chk("cfg3", synth_three_cfg, 19'h12345);
        chk("cfg1_sel", synth_one_cfg, {11'h103, 8'h13});
        sd <= 1'b0;
        wt();
        chk("full_sd", {osc_run, synth_run, out_en}, 9'h0);
        sd   <= 1'b1;
        seen = 1'b0;
        repeat (12) begin
            @(posedge pclk);
            if (relock === 1'b1)
                seen = 1'b1;
        end
        chk("relock", seen, 1'b1);
        wt();
        chk("run_again", {osc_run, synth_run, out_en}, 9'h1ff);
        apb(1'b1, OFS_CTRL, 32'h0);
        sd <= 1'b0;
        wt();
        chk("oe_only", {osc_run, synth_run, out_en}, 9'h1e0);
        sd <= 1'b1;
        // Synth one suspended together with every output it can feed
        apb(1'b1, OFS_CTRL, 32'h266);
        wt();
        chk("suspend", {synth_run, out_en}, 8'b110_01100);
        sel <= 1'b1;
        wt();
        chk("wake", {synth_run, out_en}, 8'hff);
        apb(1'b0, OFS_STAT, 32'h0);
        chk("idx_bit2", rd_data[2:0], 3'h3);
        apb(1'b0, 8'h1c, 32'h0);
        chk("unmapped", {rd_err, rd_data}, {1'b1, 32'h0});
        end_of_test();
    end
endmodule : pfs_ctrl_tb

bind pfs_ctrl pfs_ctrl_props props_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .shutdown_oe_n(shutdown_oe_n), .out_en(out_en), .synth_run(synth_run), .osc_run(osc_run),
    .relock(relock), .divs(divs), .divs_update(divs_update));
